// ---- hw/lfc_params.svh ----
// Register offsets, field positions, reset values and timing counts of the link format block.
`ifndef LFC_PARAMS_SVH
`define LFC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define LFC_ADDR_RESERVED_SIX   8'h06
`define LFC_ADDR_LINK_FORMAT    8'h07
`define LFC_RESERVED_SIX_VALUE  8'h02
`define LFC_UNMAPPED_READ       8'h00

// ----------------------------------------------------------------------------
// Field positions inside the link format control register
// ----------------------------------------------------------------------------
`define LFC_BIT_TWO_WORD        7
`define LFC_BIT_WORD_WIDTH      5
`define LFC_BIT_CLOCK_EDGE      4
`define LFC_BIT_SYNC_TRACK      3
`define LFC_BIT_SYNC_CODE       2
`define LFC_ERR_MSB             1
`define LFC_ERR_LSB             0

// ----------------------------------------------------------------------------
// Error check codes
// ----------------------------------------------------------------------------
`define LFC_ERR_PARITY          2'h0
`define LFC_ERR_CRC             2'h1
`define LFC_ERR_HAMMING         2'h2
`define LFC_ERR_FORBIDDEN       2'h3

// ----------------------------------------------------------------------------
// Strap capture timing
// ----------------------------------------------------------------------------
`define LFC_STRAP_SETTLE_CYCLES 3'h4

`endif

// ---- hw/lfc_pkg.sv ----
// Types shared by the link format configuration block.
package lfc_pkg;

  // Controller states: wait for straps to settle, then run.
  typedef enum logic [1:0] {
    LFC_ST_SETTLE = 2'b01,
    LFC_ST_RUN    = 2'b10
  } lfc_state_e;

  // Decoded link format settings driven to the datapath.
  typedef struct packed {
    logic       two_word_per_clock_select;
    logic       word_width_select;
    logic       clock_edge_choice;
    logic       sync_tracking_enable;
    logic       sync_code_enable;
    logic [1:0] link_error_check_select;
  } lfc_cfg_s;

  // Strap levels sampled at power-up.
  typedef struct packed {
    logic local_control_link_pin;
    logic double_output_strap_pin;
    logic width_strap_pin;
    logic edge_strap_pin;
    logic sync_strap_pin;
    logic error_check_strap_pin;
  } lfc_strap_s;

endpackage

// ---- hw/lfc_link_format_config.sv ----
// Link format configuration register with strap-loaded power-up defaults.
`timescale 1ns/1ps
`include "lfc_params.svh"

module lfc_link_format_config (
  input  wire logic              clk_sys_in,
  input  wire logic              reset_in,
  input  wire lfc_pkg::lfc_strap_s strap_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  output logic [7:0]             reg_rdata_out,
  output logic                   reg_rvalid_out,
  output logic                   ready_out,
  output lfc_pkg::lfc_cfg_s      cfg_out,
  output logic                   edge_falling_out
);

  // --------------------------------------------------------------------------
  // Strap synchronisers
  // --------------------------------------------------------------------------
  localparam int STRAP_W = $bits(lfc_pkg::lfc_strap_s);

  logic [STRAP_W-1:0] sync1_r;
  logic [STRAP_W-1:0] sync2_r;
  logic [STRAP_W-1:0] sync3_r;
  logic [STRAP_W-1:0] strap_f_r;
  logic [STRAP_W-1:0] strap_f_nxt;

  // Each strap passes three flops; a change counts once flops two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < STRAP_W; gi++) begin : g_sync
      assign strap_f_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : strap_f_r[gi];
    end
  endgenerate

  // Shift the straps through the synchroniser chain.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sync1_r   <= '0;
      sync2_r   <= '0;
      sync3_r   <= '0;
      strap_f_r <= '0;
    end else begin
      sync1_r   <= strap_in;
      sync2_r   <= sync1_r;
      sync3_r   <= sync2_r;
      strap_f_r <= strap_f_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Power-up defaults from straps
  // --------------------------------------------------------------------------
  lfc_pkg::lfc_strap_s strap_w;
  logic                strap_use;
  lfc_pkg::lfc_cfg_s   strap_cfg;

  // Gates one strap level by the local control link pin; used for every strapped field.
  function automatic logic strap_gate(input logic use_straps, input logic pin);
    return use_straps & pin;
  endfunction

  // Straps only count while the local control link pin is low. With that pin high
  // every field falls back to zero, which is also the parity check code.
  assign strap_w   = lfc_pkg::lfc_strap_s'(strap_f_r);
  assign strap_use = ~strap_w.local_control_link_pin;
  assign strap_cfg.two_word_per_clock_select =
           strap_gate(strap_use, strap_w.double_output_strap_pin);
  assign strap_cfg.word_width_select         =
           strap_gate(strap_use, strap_w.width_strap_pin);
  assign strap_cfg.clock_edge_choice         =
           strap_gate(strap_use, strap_w.edge_strap_pin);
  assign strap_cfg.sync_tracking_enable      =
           strap_gate(strap_use, strap_w.sync_strap_pin);
  assign strap_cfg.sync_code_enable          =
           strap_gate(strap_use, strap_w.sync_strap_pin);
  assign strap_cfg.link_error_check_select   =
           strap_gate(strap_use, strap_w.error_check_strap_pin) ?
           `LFC_ERR_HAMMING : `LFC_ERR_PARITY;

  // --------------------------------------------------------------------------
  // Register access decode
  // --------------------------------------------------------------------------
  lfc_pkg::lfc_state_e state_r;
  lfc_pkg::lfc_state_e state_nxt;
  logic [2:0]          settle_r;
  logic [2:0]          settle_nxt;
  lfc_pkg::lfc_cfg_s   cfg_r;
  lfc_pkg::lfc_cfg_s   cfg_nxt;
  lfc_pkg::lfc_cfg_s   cfg_wr;
  logic                hit_six;
  logic                hit_seven;
  logic                running;
  logic                wr_seven;
  logic                err_ok;
  logic [7:0]          ctrl_view;
  logic [7:0]          rdata_nxt;
  logic                rd_take;
  logic [7:0]          rd_answer;
  logic                run_coming;

  assign running   = (state_r == lfc_pkg::LFC_ST_RUN);
  assign hit_six   = (reg_addr_in == `LFC_ADDR_RESERVED_SIX);
  assign hit_seven = (reg_addr_in == `LFC_ADDR_LINK_FORMAT);
  assign wr_seven  = running & reg_wr_in & hit_seven;

  // The forbidden check code is refused; the field keeps its old value.
  assign err_ok = (reg_wdata_in[`LFC_ERR_MSB:`LFC_ERR_LSB] != `LFC_ERR_FORBIDDEN);

  // Written fields; the edge bit is taken as given, software stops the clock first.
  // Nothing guards the edge bit here, so a running pixel clock would see the edge move.
  assign cfg_wr.two_word_per_clock_select = reg_wdata_in[`LFC_BIT_TWO_WORD];
  assign cfg_wr.word_width_select         = reg_wdata_in[`LFC_BIT_WORD_WIDTH];
  assign cfg_wr.clock_edge_choice         = reg_wdata_in[`LFC_BIT_CLOCK_EDGE];
  assign cfg_wr.sync_tracking_enable      = reg_wdata_in[`LFC_BIT_SYNC_TRACK];
  assign cfg_wr.sync_code_enable          = reg_wdata_in[`LFC_BIT_SYNC_CODE];
  assign cfg_wr.link_error_check_select   = err_ok ?
                                            reg_wdata_in[`LFC_ERR_MSB:`LFC_ERR_LSB] :
                                            cfg_r.link_error_check_select;

  // Read view of the control register; the data-rate bit D6 reads zero.
  always_comb begin
    ctrl_view                               = 8'h00;
    ctrl_view[`LFC_BIT_TWO_WORD]            = cfg_r.two_word_per_clock_select;
    ctrl_view[`LFC_BIT_WORD_WIDTH]          = cfg_r.word_width_select;
    ctrl_view[`LFC_BIT_CLOCK_EDGE]          = cfg_r.clock_edge_choice;
    ctrl_view[`LFC_BIT_SYNC_TRACK]          = cfg_r.sync_tracking_enable;
    ctrl_view[`LFC_BIT_SYNC_CODE]           = cfg_r.sync_code_enable;
    ctrl_view[`LFC_ERR_MSB:`LFC_ERR_LSB]    = cfg_r.link_error_check_select;
  end

  // Register six always reads its fixed pattern and ignores writes.
  assign rdata_nxt = hit_six   ? `LFC_RESERVED_SIX_VALUE :
                     hit_seven ? ctrl_view : `LFC_UNMAPPED_READ;

  // A read is answered only once the defaults are loaded. A read in the same cycle as a
  // write returns the old value, because the configuration register updates on that edge.
  assign rd_take   = running & reg_rd_in;
  assign rd_answer = rd_take ? rdata_nxt : 8'h00;

  // --------------------------------------------------------------------------
  // Controller: settle straps, load defaults once, then accept writes
  // --------------------------------------------------------------------------
  // The settle count covers the three synchroniser flops and the agree filter, so the
  // filtered straps are steady when the defaults are copied. Later strap changes are
  // ignored: the defaults load once per reset.
  always_comb begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    cfg_nxt    = cfg_r;
    unique case (state_r)
      lfc_pkg::LFC_ST_SETTLE: begin
        settle_nxt = settle_r + 3'h1;
        if (settle_r == `LFC_STRAP_SETTLE_CYCLES) begin
          cfg_nxt   = strap_cfg;
          state_nxt = lfc_pkg::LFC_ST_RUN;
        end
      end
      lfc_pkg::LFC_ST_RUN: begin
        if (wr_seven) begin
          cfg_nxt = cfg_wr;
        end
      end
      default: begin
        state_nxt  = lfc_pkg::LFC_ST_SETTLE;
        settle_nxt = 3'h0;
      end
    endcase
  end

  // Ready looks one state ahead, so it rises on the edge that loads the defaults.
  assign run_coming = (state_nxt == lfc_pkg::LFC_ST_RUN);

  // State, settle counter and configuration register.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r  <= lfc_pkg::LFC_ST_SETTLE;
      settle_r <= 3'h0;
      cfg_r    <= '0;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
      cfg_r    <= cfg_nxt;
    end
  end

  // Read answer: data and valid stand for one cycle after an accepted read, else zero.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rdata_out  <= rd_answer;
      reg_rvalid_out <= rd_take;
    end
  end

  // Status outputs; the edge flag follows the configuration register on the same edge.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ready_out        <= 1'b0;
      edge_falling_out <= 1'b0;
    end else begin
      ready_out        <= run_coming;
      edge_falling_out <= cfg_nxt.clock_edge_choice;
    end
  end

  // Configuration to the datapath, straight from the register.
  assign cfg_out = cfg_r;

endmodule // lfc_link_format_config

// ---- sim/lfc_asserts.sv ----
// Port checker for the link format configuration register.
`timescale 1ns/1ps
module lfc_asserts (
  input wire logic                clk_sys_in,
  input wire logic                reset_in,
  input wire lfc_pkg::lfc_strap_s strap_in,
  input wire logic                reg_wr_in,
  input wire logic                reg_rd_in,
  input wire logic [7:0]          reg_addr_in,
  input wire logic [7:0]          reg_wdata_in,
  input wire logic [7:0]          reg_rdata_out,
  input wire logic                reg_rvalid_out,
  input wire logic                ready_out,
  input wire lfc_pkg::lfc_cfg_s   cfg_out,
  input wire logic                edge_falling_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Accepted accesses and the strap-derived default setting.
  wire       wr7   = ready_out && reg_wr_in && reg_addr_in == 8'h07;
  wire       rd_ok = ready_out && reg_rd_in;
  wire [6:0] dflt  = strap_in.local_control_link_pin ? 7'h00 :
    {strap_in.double_output_strap_pin, strap_in.width_strap_pin, strap_in.edge_strap_pin,
     strap_in.sync_strap_pin, strap_in.sync_strap_pin, strap_in.error_check_strap_pin, 1'b0};
  a_strap_load: assert property ($rose(ready_out) |-> cfg_out == dflt)
    else $error("Strap defaults wrong");
  a_write_cfg: assert property (wr7 && reg_wdata_in[1:0] != 2'h3 |=>
    cfg_out == {$past(reg_wdata_in[7]), $past(reg_wdata_in[5:0])}) else $error("Write lost");
  a_err_refuse: assert property (wr7 && reg_wdata_in[1:0] == 2'h3 |=>
    cfg_out[1:0] == $past(cfg_out[1:0])) else $error("Forbidden check code taken");
  a_cfg_hold: assert property (ready_out && !wr7 |=> $stable(cfg_out))
    else $error("Setting changed without write");
  a_edge_copy: assert property (edge_falling_out == cfg_out.clock_edge_choice)
    else $error("Edge output disagrees");
  a_read_pulse: assert property (rd_ok |=> reg_rvalid_out) else $error("Read not answered");
  a_no_spur: assert property (!rd_ok |=> !reg_rvalid_out && reg_rdata_out == 8'h00)
    else $error("Spurious read data");
  a_read_seven: assert property (rd_ok && reg_addr_in == 8'h07 && !reg_wr_in |=>
    reg_rdata_out == {cfg_out[6], 1'b0, cfg_out[5:0]}) else $error("Readback wrong");
  a_read_six: assert property (rd_ok && reg_addr_in == 8'h06 |=>
    reg_rdata_out == 8'h02) else $error("Reserved readback wrong");
endmodule // lfc_asserts

// ---- sim/lfc_mcu_model.sv ----
// Control-channel master that issues single register accesses.
`timescale 1ns/1ps
module lfc_mcu_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out
);
  // Idle bus at time zero.
  initial begin
    {wr_out, rd_out, addr_out, wdata_out} = '0;
  end
  // One-cycle write; edge bit writes are issued only with no pixel clock running.
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in); #1;
    wr_out = 1'b1; addr_out = a; wdata_out = d;
    @(posedge clk_in); #1;
    wr_out = 1'b0; addr_out = ~a; wdata_out = ~d;
  endtask
  // One-cycle read; the answer is taken one cycle after the strobe.
  task automatic get(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_in); #1;
    rd_out = 1'b1; addr_out = a;
    @(posedge clk_in); #1;
    rd_out = 1'b0; addr_out = ~a;
    d = rdata_in; v = rvalid_in;
  endtask
endmodule // lfc_mcu_model

// ---- sim/testbench.sv ----
// Self-checking bench for the link format configuration register.
`timescale 1ns/1ps
module testbench;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, wr, rd, rvalid, ready, efall, v;
  logic [7:0] addr, wdata, rdata, d, e7;
  lfc_pkg::lfc_strap_s strap = '0;
  lfc_pkg::lfc_cfg_s   cfg;
  int errors = 0, comparisons = 0, cycles = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  lfc_link_format_config uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .strap_in(strap),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .ready_out(ready), .cfg_out(cfg),
    .edge_falling_out(efall));
  lfc_mcu_model mcu (.clk_in(clk_sys_in), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
  // Compare and count.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read a register and compare the answer and its valid pulse.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    mcu.get(a, d, v);
    chk({7'h0, v}, 8'h01);
    chk(d, exp);
  endtask
  // Reset with given straps, wait for ready, compare the loaded defaults.
  task automatic test_straps(input lfc_pkg::lfc_strap_s s);
    reset_in = 1'b1; strap = s;
    repeat (6) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    for (int i = 0; i < 20 && ready !== 1'b1; i++) begin
      @(posedge clk_sys_in); #1;
    end
    e7 = s[5] ? 8'h00 : {s[4], 1'b0, s[3], s[2], s[1], s[1], s[0], 1'b0};
    chk({7'h0, ready}, 8'h01);
    chk({1'b0, cfg}, {1'b0, e7[7], e7[5:0]});
    rd_chk(8'h07, e7);
  endtask
  // Writes across every check code, D6 ignored, code 11 refused.
  task automatic test_writes;
    logic [7:0] vals [5] = '{8'hbe, 8'h41, 8'h00, 8'hff, 8'h96};
    foreach (vals[i]) begin
      e7 = {vals[i][7], 1'b0, vals[i][5:2], vals[i][1:0] == 2'h3 ? e7[1:0] : vals[i][1:0]};
      mcu.put(8'h07, vals[i]);
      chk({1'b0, cfg}, {1'b0, e7[7], e7[5:0]});
      chk({7'h0, efall}, {7'h0, e7[4]});
      rd_chk(8'h07, e7);
    end
  endtask
  // Reserved register, its documented rewrite, and an unmapped address.
  task automatic test_reserved;
    rd_chk(8'h06, 8'h02);
    mcu.put(8'h06, 8'h02);
    rd_chk(8'h06, 8'h02);
    rd_chk(8'h07, e7);
    rd_chk(8'h3c, 8'h00);
  endtask
  // Print counts and the verdict.
  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard.
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      finish_test();
    end
  end
  // Main sequence.
  initial begin
    test_straps(6'b011111);
    test_straps(6'b001011);
    test_writes();
    test_reserved();
    test_straps(6'b111111);
    finish_test();
  end
endmodule // testbench
bind lfc_link_format_config lfc_asserts u_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
  .strap_in(strap_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .ready_out(ready_out), .cfg_out(cfg_out), .edge_falling_out(edge_falling_out));
